// *** dv/ast_remote_peer.sv ***
// Purpose: Remote serial peer that sends frames and decodes frames.
// Assumes: Eight data bits, no parity, one stop bit, BIT clocks a bit.
// Notes: The line idles high; a low stop bit forces a framing fault.
`timescale 1ns/1ns
module ast_remote_peer #(
  parameter int BIT = 32
) (
  // Clock and lines.
  input wire logic mclk,
  input wire logic txLine,
  output logic rxLine
);
  logic [7:0] got[$];
  logic [7:0] sh;
  // ******
  // Decoder
  // ******
  initial rxLine = 1'b1;
  // Samples mid bit, so a stop bit cut short is seen.
  always begin
    @(negedge txLine);
    repeat (BIT / 2) @(posedge mclk);
    if (txLine === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge mclk);
        sh[i] = txLine;
      end
      repeat (BIT) @(posedge mclk);
      if (txLine === 1'b1) got.push_back(sh);
    end
  end
  // Sends start, data LSB first, then the given stop level.
  task automatic sendFrame(input logic [7:0] d, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk) rxLine <= f[i];
      repeat (BIT - 1) @(negedge mclk);
    end
    @(negedge mclk) rxLine <= 1'b1;
  endtask
endmodule

// *** dv/async_serial_transceiver_test.sv ***
// Purpose: Self-checking bench for the async serial transceiver.
// Assumes: Divisor 2 with no fraction, so a bit lasts 32 clocks.
// Notes: Inputs change on the falling clock edge.
`timescale 1ns/1ns
module async_serial_transceiver_test;
  import ast_pkg::*;
  localparam int BIT = 32;
  logic mclk, rst, ctrlWrite, intDivWrite, fracDivWrite, lineCtrlWrite, levelWrite;
  logic maskWrite, errClear, txWrite, rxRead, busy, txEmptyFlag, txFullFlag;
  logic rxEmptyFlag, rxFullFlag, overrunStatus, irq, serialRxLine, serialTxLine;
  logic [3:0] ctrlValue;
  logic [15:0] intDivValue;
  logic [5:0] fracDivValue;
  logic [7:0] lineCtrlValue, txData, b;
  logic [2:0] txLevelValue, rxLevelValue;
  logic [6:0] maskValue, intClear, rawStatus, maskedStatus;
  logic [11:0] rxData;
  int miscompares, totalChecks, cycles, seed, n;
  logic [7:0] sent[$];
  // ******
  // Harness
  // ******
  ast_transceiver i_dut (.mclk(mclk), .rst(rst), .ctrlValue(ctrlValue),
    .ctrlWrite(ctrlWrite), .intDivValue(intDivValue), .intDivWrite(intDivWrite),
    .fracDivValue(fracDivValue), .fracDivWrite(fracDivWrite),
    .lineCtrlValue(lineCtrlValue), .lineCtrlWrite(lineCtrlWrite),
    .txLevelValue(txLevelValue), .rxLevelValue(rxLevelValue), .levelWrite(levelWrite),
    .maskValue(maskValue), .maskWrite(maskWrite), .intClear(intClear),
    .errClear(errClear), .txData(txData), .txWrite(txWrite), .rxRead(rxRead),
    .rxData(rxData), .busy(busy), .txEmptyFlag(txEmptyFlag), .txFullFlag(txFullFlag),
    .rxEmptyFlag(rxEmptyFlag), .rxFullFlag(rxFullFlag), .overrunStatus(overrunStatus),
    .rawStatus(rawStatus), .maskedStatus(maskedStatus), .irq(irq),
    .serialRxLine(serialRxLine), .serialTxLine(serialTxLine));
  ast_remote_peer #(.BIT(BIT)) i_peer (.mclk(mclk), .txLine(serialTxLine),
    .rxLine(serialRxLine));
  // Free-running clock at 100 ns.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tallyAndFinish();
    end
  end
  // ******
  // Tasks
  // ******
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tallyAndFinish();
    $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic setCtrl(input logic [3:0] c);
    @(negedge mclk) {ctrlValue, ctrlWrite} <= {c, 1'b1};
    @(negedge mclk) ctrlWrite <= 1'b0;
  endtask
  // Disables first, since reprogramming a live link is not allowed.
  task automatic cfg(input logic [3:0] c, input logic [7:0] lc);
    setCtrl(4'h6);
    @(negedge mclk) {intDivWrite, fracDivWrite} <= 2'b11;
    @(negedge mclk) {intDivWrite, fracDivWrite, lineCtrlValue, lineCtrlWrite} <= {2'b0, lc, 1'b1};
    @(negedge mclk) lineCtrlWrite <= 1'b0;
    setCtrl(c);
  endtask
  task automatic sendByte(input logic [7:0] d);
    sent.push_back(d);
    @(negedge mclk) {txData, txWrite} <= {d, 1'b1};
  endtask
  task automatic waitIdle();
    n = 0;
    while (busy !== 1'b0 && n < 60 * BIT) @(negedge mclk) n++;
  endtask
  task automatic rxCheck(input logic [11:0] exp);
    n = 0;
    while (rxEmptyFlag !== 1'b0 && n < 40 * BIT) @(negedge mclk) n++;
    @(negedge mclk) rxRead <= 1'b1;
    @(negedge mclk) rxRead <= 1'b0;
    check("rxData", exp, rxData);
  endtask
  // ******
  // Sequence
  // ******
  initial begin
    seed = 32'heb338b58;
    {ctrlWrite, intDivWrite, fracDivWrite, lineCtrlWrite, levelWrite} = 5'h00;
    {maskWrite, errClear, txWrite, rxRead, rst} = 5'h01;
    {ctrlValue, txData, lineCtrlValue, maskValue, intClear} = 34'h0;
    {intDivValue, fracDivValue, txLevelValue, rxLevelValue} = {16'h0002, 12'h002};
    repeat (2) @(negedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check("txEmpty", 12'h001, {11'h0, txEmptyFlag});
    check("busyIdle", 12'h000, {11'h0, busy});
    cfg(4'h7, 8'h70);
    repeat (3) sendByte(8'($random(seed)));
    @(negedge mclk) txWrite <= 1'b0;
    check("busy", 12'h001, {11'h0, busy});
    waitIdle();
    check("txCount", 12'h003, 12'(i_peer.got.size()));
    foreach (sent[i]) check("txByte", {4'h0, sent[i]}, {4'h0, i_peer.got[i]});
    b = 8'($random(seed));
    i_peer.sendFrame(b, 1'b1);
    rxCheck({4'h0, b});
    i_peer.sendFrame(8'ha5, 1'b0);
    rxCheck(12'h1a5);
    i_peer.sendFrame(8'h00, 1'b0);
    rxCheck(12'h500);
    @(negedge mclk) {maskValue, maskWrite} <= {7'h08, 1'b1};
    @(negedge mclk) maskWrite <= 1'b0;
    check("irq", 12'h001, {11'h0, irq});
    check("masked", 12'h008, {5'h0, maskedStatus});
    @(negedge mclk) intClear <= 7'h08;
    @(negedge mclk) intClear <= 7'h00;
    check("feRaw", 12'h000, {11'h0, rawStatus[IS_FE]});
    check("irqOff", 12'h000, {11'h0, irq});
    sendByte(8'h3c);
    @(negedge mclk) txWrite <= 1'b0;
    repeat (3 * BIT) @(negedge mclk);
    setCtrl(4'h6);
    waitIdle();
    check("txFinish", 12'h004, 12'(i_peer.got.size()));
    cfg(4'hf, 8'h70);
    b = 8'($random(seed));
    sendByte(b);
    @(negedge mclk) txWrite <= 1'b0;
    rxCheck({4'h0, b});
    tallyAndFinish();
  end
endmodule

// *** rtl/ast_fifo_mem.sv ***
// Purpose: Sixteen-entry FIFO store with a registered head word.
// Assumes: The caller never pushes when full or pops when empty.
// Notes: The head register bypasses the memory so a fresh word is ready at once.
`timescale 1ns/1ns
module ast_fifo_mem import ast_pkg::*; #(
  parameter int W = TX_W
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Fill side.
  input wire logic push,
  input wire logic [W-1:0] din,
  // Drain side.
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic [CNT_W-1:0] count
);
  logic [W-1:0] mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wrPtr_r;
  logic [PTR_W-1:0] rdPtr_r;
  logic [PTR_W-1:0] rdPtr_nxt;

  assign rdPtr_nxt = pop ? rdPtr_r + 4'h1 : rdPtr_r;

  // Storage has no reset; only the pointers define validity.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_r] <= din;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr_r <= 4'h0;
      rdPtr_r <= 4'h0;
      count <= 5'h00;
    end else begin
      rdPtr_r <= rdPtr_nxt;
      if (push) begin
        wrPtr_r <= wrPtr_r + 4'h1;
      end
      if (push && !pop) begin
        count <= count + 5'h01;
      end else if (pop && !push) begin
        count <= count - 5'h01;
      end
    end
  end

  // Head word; a push into the new head slot is forwarded directly.
  always_ff @(posedge mclk) begin
    if (rst) begin
      dout <= '0;
    end else begin
      dout <= (push && wrPtr_r == rdPtr_nxt) ? din : mem[rdPtr_nxt];
    end
  end
endmodule

// *** rtl/ast_pkg.sv ***
// Purpose: Constants, types and helpers for the async serial transceiver.
// Assumes: One 10 MHz clock mclk and a synchronous active-high reset.
// Notes: Control, configuration and status bits are plain ports, no bus.
// Notes on behaviour
// [R1] Separate transmit and receive enables, both set after reset.
// [R2] Clearing global enable mid character lets that character finish.
// [R3] Software clears global enable before reprogramming any control bits.
// [R4] Frame is start, data LSB first, optional parity, then stop bits.
// [R5] Receiver checks overrun, parity, framing, break; flags stored with data.
// [R6] Divisor is 16-bit integer plus 6-bit fraction in two registers.
// [R7] Divisor makes a 16x reference; divided by 16 to time transmit.
// [R8] Divisors and line control load one 30-bit register on line control write.
// [R9] Two sixteen-entry FIFOs; receive entries carry four status bits.
// [R10] Keep sending while data waits; busy until FIFO empty and stop sent.
// [R11] Falling line starts receive; start accepted if still low at eighth tick.
// [R12] Data bits sampled every sixteenth tick; parity checked when enabled.
// [R13] Stop must sample high or framing error; character then pushed.
// [R14] Data read gives twelve bits; data write pushes eight bits.
// [R15] After reset FIFOs act as single entries; fifo enable gives full depth.
// [R16] Flags show transmit and receive empty and full; status shows overrun.
// [R17] Each FIFO has its own trigger level, one half after reset.
// [R18] Seven interrupt sources are ORed onto one request line.
// [R19] Mask gates sources; raw stays readable; masked is raw AND mask.
// [R20] Writing one to a clear bit clears that raw and masked source.
// [R21] Receive flag follows trigger level or single entry; clear bit clears.
// [R22] Transmit flag sets on downward crossing or empty entry; clear bit clears.
// [R23] Loopback routes transmit output internally to receive input.
// [R24] Overrun, data bit 11, sets when a character arrives to a full FIFO.
// [R25] Break is line low through a whole character frame.
// [R26] Timeout fires when data waits and no character arrives for a while.
package ast_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int TX_W = 8;
  localparam int RX_W = 12;
  localparam logic [CNT_W-1:0] DEPTH_FULL = 5'h10;
  localparam logic [CNT_W-1:0] DEPTH_ONE = 5'h01;
  // ****************************************************************
  // Control and line control fields
  // ****************************************************************
  localparam int CTL_EN = 0;
  localparam int CTL_TXE = 1;
  localparam int CTL_RXE = 2;
  localparam int CTL_LBE = 3;
  localparam logic [3:0] CTL_RESET = 4'h6;
  localparam int LCR_BRK = 0;
  localparam int LCR_PEN = 1;
  localparam int LCR_EPS = 2;
  localparam int LCR_STP2 = 3;
  localparam int LCR_FEN = 4;
  localparam int LCR_WLEN = 5;
  localparam int LCR_SPS = 7;
  localparam logic [29:0] SHADOW_RESET = 30'h0000_0000;
  localparam logic [15:0] DIVI_RESET = 16'h0000;
  localparam logic [5:0] DIVF_RESET = 6'h00;
  localparam logic [2:0] LVL_RESET = 3'h2;
  localparam logic [6:0] MASK_RESET = 7'h00;
  // ****************************************************************
  // Interrupt source and receive entry bit positions
  // ****************************************************************
  localparam int IS_RX = 0;
  localparam int IS_TX = 1;
  localparam int IS_RT = 2;
  localparam int IS_FE = 3;
  localparam int IS_PE = 4;
  localparam int IS_BE = 5;
  localparam int IS_OE = 6;
  localparam int DR_FE = 8;
  localparam int DR_PE = 9;
  localparam int DR_BE = 10;
  localparam int DR_OE = 11;
  // ****************************************************************
  // Oversampling timing
  // ****************************************************************
  localparam logic [3:0] SUB_START = 4'h7;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam int TIMEOUT_BITS = 32;
  localparam logic [9:0] TIMEOUT_TICKS = 10'(TIMEOUT_BITS * 16);
  // ****************************************************************
  // Types and helpers
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_START = 3'h1, ST_DATA = 3'h3, ST_PAR = 3'h2, ST_STOP = 3'h6
  } ast_state_t;
  // Trigger level select to a fill count out of sixteen.
  function automatic logic [CNT_W-1:0] ast_level(input logic [2:0] sel);
    case (sel)
      3'h0: ast_level = 5'h02;
      3'h1: ast_level = 5'h04;
      3'h3: ast_level = 5'h0C;
      3'h4: ast_level = 5'h0E;
      default: ast_level = 5'h08;
    endcase
  endfunction
  // Word length field to index of the last data bit.
  function automatic logic [2:0] ast_last_bit(input logic [1:0] wlen);
    ast_last_bit = 3'h4 + {1'b0, wlen};
  endfunction
endpackage

// *** rtl/ast_transceiver.sv ***
// Purpose: Async serial transceiver with fractional baud, FIFOs, status.
// Assumes: Strobe inputs come from logic on mclk; serialRxLine is a pin.
// Notes: Start of transmit is aligned to a 16x reference tick.
`timescale 1ns/1ns
module ast_transceiver import ast_pkg::*; (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Control register: {loopback, receive, transmit, global enable}.
  input wire logic [3:0] ctrlValue,
  input wire logic ctrlWrite,
  // Divisor and line control registers.
  input wire logic [15:0] intDivValue,
  input wire logic intDivWrite,
  input wire logic [5:0] fracDivValue,
  input wire logic fracDivWrite,
  input wire logic [7:0] lineCtrlValue,
  input wire logic lineCtrlWrite,
  // Level select, mask and clear.
  input wire logic [2:0] txLevelValue,
  input wire logic [2:0] rxLevelValue,
  input wire logic levelWrite,
  input wire logic [6:0] maskValue,
  input wire logic maskWrite,
  input wire logic [6:0] intClear,
  input wire logic errClear,
  // Data register.
  input wire logic [7:0] txData,
  input wire logic txWrite,
  input wire logic rxRead,
  output logic [11:0] rxData,
  // Flags and status.
  output logic busy,
  output logic txEmptyFlag,
  output logic txFullFlag,
  output logic rxEmptyFlag,
  output logic rxFullFlag,
  output logic overrunStatus,
  output logic [6:0] rawStatus,
  output logic [6:0] maskedStatus,
  output logic irq,
  // Serial lines.
  input wire logic serialRxLine,
  output logic serialTxLine
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [3:0] ctrl_r;
  logic [15:0] intDiv_r;
  logic [5:0] fracDiv_r;
  logic [29:0] shadow_r;
  logic [2:0] txLevel_r;
  logic [2:0] rxLevel_r;
  logic [6:0] mask_r;
  logic [15:0] divI;
  logic [5:0] divF;
  logic [7:0] lcr;

  // Separate divisor stores; the live copy moves only on line control writes.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= CTL_RESET; // R1
      intDiv_r <= DIVI_RESET;
      fracDiv_r <= DIVF_RESET;
      shadow_r <= SHADOW_RESET;
      txLevel_r <= LVL_RESET; // R17
      rxLevel_r <= LVL_RESET;
      mask_r <= MASK_RESET;
    end else begin
      if (ctrlWrite) ctrl_r <= ctrlValue;
      if (intDivWrite) intDiv_r <= intDivValue; // R6
      if (fracDivWrite) fracDiv_r <= fracDivValue;
      if (lineCtrlWrite) shadow_r <= {intDiv_r, fracDiv_r, lineCtrlValue}; // R8
      if (levelWrite) begin
        txLevel_r <= txLevelValue;
        rxLevel_r <= rxLevelValue;
      end
      if (maskWrite) mask_r <= maskValue;
    end
  end
  assign divI = shadow_r[29:14];
  assign divF = shadow_r[13:8];
  assign lcr = shadow_r[7:0];

  // ****************************************************************
  // Fractional baud generator
  // ****************************************************************
  logic [15:0] baudCnt_r;
  logic [5:0] fracAcc_r;
  logic [6:0] fracSum;
  logic tick16;
  assign fracSum = {1'b0, fracAcc_r} + {1'b0, divF};
  assign tick16 = (baudCnt_r == 16'h0000) && (divI != 16'h0000); // R7

  // A fraction carry stretches one period by a clock to average the rate.
  always_ff @(posedge mclk) begin
    if (rst || lineCtrlWrite) begin
      baudCnt_r <= 16'h0000;
      fracAcc_r <= 6'h00;
    end else if (tick16) begin
      baudCnt_r <= divI - 16'h0001 + {15'h0000, fracSum[6]}; // R7
      fracAcc_r <= fracSum[5:0];
    end else if (baudCnt_r != 16'h0000) begin
      baudCnt_r <= baudCnt_r - 16'h0001;
    end
  end

  // ****************************************************************
  // FIFOs
  // ****************************************************************
  logic [CNT_W-1:0] txCount, rxCount, depth;
  logic [7:0] txHead;
  logic [11:0] rxHead;
  logic txPush, txPop, rxPush, rxPop;
  logic [11:0] rxEntry_r;
  logic rxDone_r, oePend_r;

  assign depth = lcr[LCR_FEN] ? DEPTH_FULL : DEPTH_ONE; // R15
  assign txEmptyFlag = (txCount == 5'h00); // R16
  assign txFullFlag = (txCount >= depth);
  assign rxEmptyFlag = (rxCount == 5'h00);
  assign rxFullFlag = (rxCount >= depth);
  assign txPush = txWrite && !txFullFlag; // R14
  assign rxPop = rxRead && !rxEmptyFlag;
  assign rxPush = rxDone_r && !rxFullFlag; // R13

  ast_fifo_mem #(.W(TX_W)) txFifo ( // R9
    .mclk(mclk), .rst(rst), .push(txPush), .din(txData),
    .pop(txPop), .dout(txHead), .count(txCount)
  );
  ast_fifo_mem #(.W(RX_W)) rxFifo (
    .mclk(mclk), .rst(rst), .push(rxPush), .din({oePend_r, rxEntry_r[10:0]}),
    .pop(rxPop), .dout(rxHead), .count(rxCount)
  );

  // Read data holds the popped twelve-bit entry until the next read.
  always_ff @(posedge mclk) begin
    if (rst) rxData <= 12'h000;
    else if (rxPop) rxData <= rxHead; // R14
  end

  // A dropped character marks the status and the next stored entry.
  always_ff @(posedge mclk) begin
    if (rst) begin
      oePend_r <= 1'b0;
      overrunStatus <= 1'b0;
    end else begin
      if (rxDone_r && rxFullFlag) oePend_r <= 1'b1; // R24
      else if (rxPush) oePend_r <= 1'b0;
      if (rxDone_r && rxFullFlag) overrunStatus <= 1'b1; // R16
      else if (errClear) overrunStatus <= 1'b0;
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  ast_state_t txState_r;
  logic [3:0] txSub_r;
  logic [2:0] txBit_r;
  logic [7:0] txShift_r;
  logic txPar_r, txLine_r, txStop2_r, txGo, txParBit;
  assign txGo = ctrl_r[CTL_EN] && ctrl_r[CTL_TXE] && !txEmptyFlag; // R10
  assign txPop = tick16 && (txState_r == ST_IDLE) && txGo;
  assign txParBit = lcr[LCR_SPS] ? !lcr[LCR_EPS] : (txPar_r ^ !lcr[LCR_EPS]);
  assign busy = !txEmptyFlag || (txState_r != ST_IDLE); // R10

  // Enable is looked at only between characters, so a frame always ends.
  always_ff @(posedge mclk) begin
    if (rst) begin
      txState_r <= ST_IDLE;
      txSub_r <= 4'h0;
      txBit_r <= 3'h0;
      txShift_r <= 8'h00;
      txPar_r <= 1'b0;
      txLine_r <= 1'b1;
      txStop2_r <= 1'b0;
    end else if (tick16) begin
      txSub_r <= txSub_r + 4'h1;
      case (txState_r)
        ST_IDLE: begin
          txSub_r <= 4'h0;
          if (txGo) begin
            txState_r <= ST_START; // R4
            txShift_r <= txHead;
            txLine_r <= 1'b0;
            txBit_r <= 3'h0;
            txStop2_r <= 1'b0;
          end
        end
        ST_START: if (txSub_r == SUB_LAST) begin
          txState_r <= ST_DATA; // R2
          txLine_r <= txShift_r[0];
          txPar_r <= txShift_r[0];
        end
        ST_DATA: if (txSub_r == SUB_LAST) begin
          if (txBit_r == ast_last_bit(lcr[LCR_WLEN+:2])) begin
            txState_r <= lcr[LCR_PEN] ? ST_PAR : ST_STOP; // R4
            txLine_r <= lcr[LCR_PEN] ? txParBit : 1'b1;
          end else begin
            txBit_r <= txBit_r + 3'h1;
            txShift_r <= {1'b0, txShift_r[7:1]};
            txLine_r <= txShift_r[1];
            txPar_r <= txPar_r ^ txShift_r[1];
          end
        end
        ST_PAR: if (txSub_r == SUB_LAST) begin
          txState_r <= ST_STOP;
          txLine_r <= 1'b1;
        end
        ST_STOP: if (txSub_r == SUB_LAST) begin
          if (lcr[LCR_STP2] && !txStop2_r) txStop2_r <= 1'b1;
          else txState_r <= ST_IDLE;
        end
        default: txState_r <= ST_IDLE;
      endcase
    end
  end

  // Send break forces the line low; output stays a flip-flop.
  always_ff @(posedge mclk) begin
    if (rst) serialTxLine <= 1'b1;
    else serialTxLine <= txLine_r && !lcr[LCR_BRK];
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  logic rxSync1_r, rxSync2_r, rxLine, rxHigh_r, rxPar_r, rxAllLow_r;
  ast_state_t rxState_r;
  logic [3:0] rxSub_r;
  logic [2:0] rxBit_r;
  logic rxExpPar;

  // The pin passes two flip-flops before any logic looks at it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxSync1_r <= 1'b1;
      rxSync2_r <= 1'b1;
    end else begin
      rxSync1_r <= serialRxLine;
      rxSync2_r <= rxSync1_r;
    end
  end
  assign rxLine = ctrl_r[CTL_LBE] ? serialTxLine : rxSync2_r; // R23
  assign rxExpPar = lcr[LCR_SPS] ? !lcr[LCR_EPS] : (rxPar_r ^ !lcr[LCR_EPS]);

  // Sampling runs on reference ticks; all samples low through stop is break.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxState_r <= ST_IDLE;
      rxSub_r <= 4'h0;
      rxBit_r <= 3'h0;
      rxHigh_r <= 1'b0;
      rxPar_r <= 1'b0;
      rxAllLow_r <= 1'b0;
      rxEntry_r <= 12'h000;
      rxDone_r <= 1'b0;
    end else begin
      rxDone_r <= 1'b0;
      if (tick16) begin
        rxHigh_r <= rxLine;
        rxSub_r <= rxSub_r + 4'h1;
        case (rxState_r)
          ST_IDLE: begin
            rxSub_r <= 4'h0;
            if (ctrl_r[CTL_EN] && ctrl_r[CTL_RXE] && rxHigh_r && !rxLine) begin
              rxState_r <= ST_START; // R11
            end
          end
          ST_START: if (rxSub_r == SUB_START) begin
            rxState_r <= rxLine ? ST_IDLE : ST_DATA; // R11
            rxSub_r <= 4'h0;
            rxBit_r <= 3'h0;
            rxPar_r <= 1'b0;
            rxAllLow_r <= 1'b1;
            rxEntry_r <= 12'h000;
          end
          ST_DATA: if (rxSub_r == SUB_LAST) begin
            rxEntry_r[rxBit_r] <= rxLine; // R12
            rxPar_r <= rxPar_r ^ rxLine;
            rxAllLow_r <= rxAllLow_r && !rxLine;
            rxBit_r <= rxBit_r + 3'h1;
            if (rxBit_r == ast_last_bit(lcr[LCR_WLEN+:2])) begin
              rxState_r <= lcr[LCR_PEN] ? ST_PAR : ST_STOP;
            end
          end
          ST_PAR: if (rxSub_r == SUB_LAST) begin
            rxEntry_r[DR_PE] <= rxLine ^ rxExpPar; // R12
            rxAllLow_r <= rxAllLow_r && !rxLine;
            rxState_r <= ST_STOP;
          end
          ST_STOP: if (rxSub_r == SUB_LAST) begin
            rxEntry_r[DR_FE] <= !rxLine; // R13
            rxEntry_r[DR_BE] <= !rxLine && rxAllLow_r; // R25
            rxDone_r <= 1'b1; // R5
            rxState_r <= ST_IDLE;
          end
          default: rxState_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Timeout and interrupt status
  // ****************************************************************
  logic [9:0] toCnt_r;
  logic [CNT_W-1:0] txCountPrev_r;
  logic rxCondPrev_r, txEmptyPrev_r, rxCond, toHit;
  logic [6:0] setEvt, levelDrop;
  assign toHit = tick16 && (toCnt_r == TIMEOUT_TICKS - 10'h001);
  assign rxCond = lcr[LCR_FEN] ? (rxCount >= ast_level(rxLevel_r)) : !rxEmptyFlag;

  // The wait restarts on any arrival or read; it counts only while data waits.
  always_ff @(posedge mclk) begin
    if (rst || rxEmptyFlag || rxDone_r || rxPop) toCnt_r <= 10'h000;
    else if (tick16 && toCnt_r != TIMEOUT_TICKS) toCnt_r <= toCnt_r + 10'h001; // R26
  end

  // History for the edge-based receive and transmit flags.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxCondPrev_r <= 1'b0;
      txEmptyPrev_r <= 1'b0;
      txCountPrev_r <= 5'h00;
    end else begin
      rxCondPrev_r <= rxCond;
      txEmptyPrev_r <= txEmptyFlag;
      txCountPrev_r <= txCount;
    end
  end

  always_comb begin
    setEvt = 7'h00;
    levelDrop = 7'h00;
    setEvt[IS_RX] = rxCond && !rxCondPrev_r; // R21
    levelDrop[IS_RX] = !rxCond;
    if (lcr[LCR_FEN]) begin
      setEvt[IS_TX] = (txCountPrev_r > ast_level(txLevel_r)) &&
                      (txCount <= ast_level(txLevel_r)); // R22
      levelDrop[IS_TX] = txCount > ast_level(txLevel_r);
    end else begin
      setEvt[IS_TX] = txEmptyFlag && !txEmptyPrev_r;
      levelDrop[IS_TX] = !txEmptyFlag;
    end
    setEvt[IS_RT] = toHit; // R26
    setEvt[IS_FE] = rxPush && rxEntry_r[DR_FE]; // R5
    setEvt[IS_PE] = rxPush && rxEntry_r[DR_PE];
    setEvt[IS_BE] = rxPush && rxEntry_r[DR_BE];
    setEvt[IS_OE] = rxDone_r && rxFullFlag; // R24
  end

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge mclk) begin
    if (rst) rawStatus <= 7'h00;
    else rawStatus <= (rawStatus & ~intClear & ~levelDrop) | setEvt; // R20
  end
  assign maskedStatus = rawStatus & mask_r; // R19
  assign irq = |maskedStatus; // R18

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence sRxStart;
    rxState_r == ST_IDLE ##1 rxState_r == ST_START;
  endsequence
  a_busy_hold: // R10
    assert property (txState_r != ST_IDLE |-> busy) else $error("busy low mid frame");
  a_start_low: // R11
    assert property (sRxStart |-> !$past(rxLine)) else $error("start without low line");
  a_start_reject: // R11
    assert property (rxState_r == ST_START && tick16 && rxSub_r == SUB_START && rxLine
      |=> rxState_r == ST_IDLE) else $error("glitch taken as start");
  a_shadow_hold: // R8
    assert property (!lineCtrlWrite |=> $stable(shadow_r)) else $error("divisor moved early");
  a_frame_levels: // R4
    assert property ((txState_r == ST_START |-> !txLine_r) and
      (txState_r == ST_STOP |-> txLine_r)) else $error("bad start or stop level");
  a_finish_char: // R2
    assert property (txState_r == ST_DATA && !ctrl_r[CTL_EN] |=> txState_r != ST_IDLE)
      else $error("frame cut short");
  a_overrun_mark: // R24
    assert property (rxDone_r && rxFullFlag |=> overrunStatus && rawStatus[IS_OE])
      else $error("overrun not flagged");
  a_clear_bit: // R20
    assert property (intClear[IS_PE] && !setEvt[IS_PE] |=> !rawStatus[IS_PE])
      else $error("clear ignored");
  a_depth_limit: // R15
    assert property (!lcr[LCR_FEN] |-> rxCount <= DEPTH_ONE && txCount <= DEPTH_ONE)
      else $error("single entry exceeded");
  a_break_frame: // R25
    assert property (rxDone_r && rxEntry_r[DR_BE] |-> rxEntry_r[DR_FE] &&
      rxEntry_r[7:0] == 8'h00) else $error("break without low frame");
endmodule
